// ---- shared/pps_pkg.sv ----
// Shared constants and types of the power path selector
package pps_pkg;

	// ==========================================
	// Timing
	// ==========================================
	localparam int CLK_PERIOD_NS = 10;
	localparam int BOOT_IGNORE_INTERVAL_US = 100;
	localparam int BOOT_CYCLES = (BOOT_IGNORE_INTERVAL_US * 1000) / CLK_PERIOD_NS;
	localparam int PACK_REMOVAL_FILTER_TIME_US = 50;
	localparam int PACK_FILTER_CYCLES = (PACK_REMOVAL_FILTER_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// ==========================================
	// Current limit codes
	// ==========================================
	localparam logic [1:0] ILIM_100MA = 2'h0;
	localparam logic [1:0] ILIM_500MA = 2'h1;
	localparam logic [1:0] ILIM_2A75  = 2'h2;
	localparam int PACK_LEVEL_W = 2;

	// ==========================================
	// Path status encoding
	// ==========================================
	typedef enum logic [2:0] {
		PPS_SRC_BATT,
		PPS_SRC_ADAPTER,
		PPS_SRC_USB,
		PPS_SRC_FORCED_BATT,
		PPS_SRC_PROTECT
	} pps_src_t;

endpackage : pps_pkg

// ---- src/pps_filter.sv ----
// Deglitch filter: output asserts after input held high for a full interval
`timescale 1ns/1ps
`default_nettype none
module pps_filter
	import pps_pkg::*;
#(
	parameter int CYCLES = 4
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Filter
	input  wire logic trip,
	output logic      filtered
);
	logic [CNT_W-1:0] count_reg;

	// ==========================================
	// Counter restarts whenever trip drops
	// ==========================================
	always_ff @(posedge clk)
	begin
		if (rst || !trip)
			count_reg <= '0;
		else if (count_reg < CNT_W'(CYCLES))
			count_reg <= count_reg + CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			filtered <= 1'b0;
		else
			filtered <= trip && (count_reg >= CNT_W'(CYCLES - 1));
	end

	a_filter_restart: assert property (@(posedge clk) disable iff (rst)
		!trip |=> !filtered) else $error("filter output without trip");

endmodule : pps_filter
`default_nettype wire

// ---- src/power_path_selector.sv ----
// Power path selector: source choice, switch control, limits, protection
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Input connected only when above battery
// - Priority adapter, then USB, then battery
// - Auto mode drives switches per detection
// - Battery on under external only if supplementing
// - Supplement need when bus below battery
// - Auto disabled forces battery, inputs off
// - Forced battery never reconnects external inputs
// - Lost source falls to next priority
// - Path state readable in status output
// - USB limit decoded from two bits
// - Adapter limit always fixed value
// - Overvoltage flags status, switches unchanged
// - Thermal shutdown: inputs off, battery on
// - Output short: inputs off, input pull-up on
// - Battery short: battery off, pull-up on
// - Boot interval ignores bits, 100 mA
// - Pack-ID source on unless sleeping
// - Pack-ID current from host level field
// - Filtered pack removal activates discharge switch
// - Charge reduced to zero before supplement
module power_path_selector
	import pps_pkg::*;
#(
	parameter int BOOT_CNT = BOOT_CYCLES,
	parameter int FILTER_CNT = PACK_FILTER_CYCLES
)(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	// Analog comparator outputs
	input  wire logic                    adapterAboveBat,
	input  wire logic                    usbAboveBat,
	input  wire logic                    busBelowBat,
	input  wire logic                    adapterOvp,
	input  wire logic                    usbOvp,
	input  wire logic                    busBelowShort,
	input  wire logic                    batBusShort,
	input  wire logic                    packIdTrip,
	input  wire logic                    thermalShutdown,
	input  wire logic                    chargeCurrentZero,
	// Host control bits
	input  wire logic                    autoPathEnable,
	input  wire logic                    usbSourceSelect,
	input  wire logic                    usb_limit_high_select,
	input  wire logic                    chargeSuspend,
	input  wire logic                    sleepMode,
	input  wire logic [PACK_LEVEL_W-1:0] pack_id_current_level,
	// Switch and pull-up controls
	output logic                         adapterSwitchOn,
	output logic                         usbSwitchOn,
	output logic                         batterySwitchOn,
	output logic                         inputPullupOn,
	output logic                         batPullupOn,
	output logic                         dischargeOn,
	output logic                         packIdSourceOn,
	output logic [PACK_LEVEL_W-1:0]      packIdLevel,
	// Limits and status
	output logic [1:0]                   usbLimitCode,
	output logic [1:0]                   adapterLimitCode,
	output logic                         chargeEnable,
	output logic                         chargeReduce,
	output logic                         supplementNeed,
	output logic                         overvoltageFlag,
	output logic                         bootActive,
	output pps_src_t                     path_status_reg
);
	localparam int NSYNC = 10;

	// ==========================================
	// Comparator synchronisers
	// ==========================================
	logic [NSYNC-1:0] syncA_reg;
	logic [NSYNC-1:0] syncB_reg;
	logic [NSYNC-1:0] rawIn;

	assign rawIn = {chargeCurrentZero, thermalShutdown, packIdTrip, batBusShort,
		busBelowShort, usbOvp, adapterOvp, busBelowBat, usbAboveBat, adapterAboveBat};

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end
		else
		begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
		end
	end

	logic adDet;
	logic usbDet;
	logic supNeed;
	logic adOv;
	logic usbOv;
	logic outShort;
	logic batShort;
	logic packTrip;
	logic thermal;
	logic chgZero;

	assign {chgZero, thermal, packTrip, batShort, outShort, usbOv, adOv, supNeed,
		usbDet, adDet} = syncB_reg;

	// ==========================================
	// Boot interval
	// ==========================================
	logic [CNT_W-1:0] bootCnt_reg;
	logic             booting;

	assign booting = bootCnt_reg < CNT_W'(BOOT_CNT);

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			bootCnt_reg <= '0;
		else if (booting)
			bootCnt_reg <= bootCnt_reg + CNT_W'(1);
	end

	logic autoEff;
	logic suspendEff;

	assign autoEff = booting ? 1'b1 : autoPathEnable;
	assign suspendEff = booting ? 1'b0 : chargeSuspend;

	// ==========================================
	// Pack removal filter
	// ==========================================
	logic packRemoved;

	pps_filter #(
		.CYCLES(FILTER_CNT)
	) u_filter (
		.clk     (ref_clk),
		.rst     (sys_rst),
		.trip    (packTrip),
		.filtered(packRemoved)
	);

	// ==========================================
	// Source selection
	// ==========================================
	pps_src_t srcNext;
	logic     adNext;
	logic     usbNext;
	logic     batNext;
	logic     inPullNext;
	logic     batPullNext;

	always_comb
	begin
		adNext = 1'b0;
		usbNext = 1'b0;
		batNext = 1'b1;
		inPullNext = 1'b0;
		batPullNext = 1'b0;
		srcNext = PPS_SRC_BATT;
		if (!autoEff)
		begin
			srcNext = PPS_SRC_FORCED_BATT;
		end
		else if (adDet)
		begin
			adNext = 1'b1;
			batNext = supNeed && chgZero;
			srcNext = PPS_SRC_ADAPTER;
		end
		else if (usbDet)
		begin
			usbNext = 1'b1;
			batNext = supNeed && chgZero;
			srcNext = PPS_SRC_USB;
		end
		if (thermal)
		begin
			adNext = 1'b0;
			usbNext = 1'b0;
			batNext = 1'b1;
			srcNext = PPS_SRC_PROTECT;
		end
		if (outShort)
		begin
			adNext = 1'b0;
			usbNext = 1'b0;
			inPullNext = 1'b1;
			srcNext = PPS_SRC_PROTECT;
		end
		if (batShort)
		begin
			batNext = 1'b0;
			batPullNext = 1'b1;
			srcNext = PPS_SRC_PROTECT;
		end
	end

	// Overvoltage deliberately absent from selection so switches keep state
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			adapterSwitchOn <= 1'b0;
			usbSwitchOn <= 1'b0;
			batterySwitchOn <= 1'b1;
			inputPullupOn <= 1'b0;
			batPullupOn <= 1'b0;
			path_status_reg <= PPS_SRC_BATT;
		end
		else
		begin
			adapterSwitchOn <= adNext;
			usbSwitchOn <= usbNext;
			batterySwitchOn <= batNext;
			inputPullupOn <= inPullNext;
			batPullupOn <= batPullNext;
			path_status_reg <= srcNext;
		end
	end

	// ==========================================
	// Limits, charge control, flags
	// ==========================================
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			usbLimitCode <= ILIM_100MA;
			adapterLimitCode <= ILIM_2A75;
			chargeEnable <= 1'b0;
			chargeReduce <= 1'b0;
			supplementNeed <= 1'b0;
			overvoltageFlag <= 1'b0;
			bootActive <= 1'b1;
		end
		else
		begin
			if (booting)
				usbLimitCode <= ILIM_100MA;
			else if (usbSourceSelect)
				usbLimitCode <= ILIM_2A75;
			else if (usb_limit_high_select)
				usbLimitCode <= ILIM_500MA;
			else
				usbLimitCode <= ILIM_100MA;
			adapterLimitCode <= ILIM_2A75;
			chargeEnable <= !suspendEff;
			chargeReduce <= supNeed && (adDet || usbDet);
			supplementNeed <= supNeed;
			overvoltageFlag <= adOv || usbOv;
			bootActive <= booting;
		end
	end

	// ==========================================
	// Pack identification and discharge
	// ==========================================
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			packIdSourceOn <= 1'b0;
			packIdLevel <= '0;
			dischargeOn <= 1'b0;
		end
		else
		begin
			packIdSourceOn <= !sleepMode;
			packIdLevel <= pack_id_current_level;
			dischargeOn <= packRemoved;
		end
	end

	// ==========================================
	// Assertions
	// ==========================================
	a_forced_battery: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!autoEff && !thermal && !outShort && !batShort) |=>
		(!adapterSwitchOn && !usbSwitchOn && batterySwitchOn))
		else $error("forced battery path wrong");
	a_no_reconnect: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!autoEff |=> !adapterSwitchOn && !usbSwitchOn)
		else $error("external input reconnected in forced mode");
	a_adapter_priority: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(autoEff && adDet && !thermal && !outShort) |=>
		(adapterSwitchOn && !usbSwitchOn)) else $error("adapter priority lost");
	a_usb_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(autoEff && !adDet && usbDet && !thermal && !outShort) |=> usbSwitchOn)
		else $error("usb not selected");
	a_fallback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(autoEff && !adDet && !usbDet && !batShort) |=> batterySwitchOn)
		else $error("battery fallback missing");
	a_supplement_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(autoEff && adDet && !chgZero && !thermal) |=> !batterySwitchOn)
		else $error("battery on before charge reached zero");
	a_thermal_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(thermal && !outShort && !batShort) |=>
		(!adapterSwitchOn && !usbSwitchOn && batterySwitchOn))
		else $error("thermal shutdown not applied");
	a_out_short: assert property (@(posedge ref_clk) disable iff (sys_rst)
		outShort |=> inputPullupOn && !adapterSwitchOn && !usbSwitchOn)
		else $error("output short handling wrong");
	a_bat_short: assert property (@(posedge ref_clk) disable iff (sys_rst)
		batShort |=> batPullupOn && !batterySwitchOn)
		else $error("battery short handling wrong");
	a_usb_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!booting && usbSourceSelect) |=> usbLimitCode == ILIM_2A75)
		else $error("usb limit decode wrong");
	a_boot_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		booting |=> usbLimitCode == ILIM_100MA && chargeEnable)
		else $error("boot limit not applied");
	a_sync_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(packIdTrip) |=> !packTrip ##1 packTrip)
		else $error("synchroniser delay wrong");
	a_pack_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sleepMode |=> !packIdSourceOn)
		else $error("pack id source on in sleep");

	c_adapter: cover property (@(posedge ref_clk) adapterSwitchOn && !batterySwitchOn);
	c_supplement: cover property (@(posedge ref_clk)
		(adapterSwitchOn || usbSwitchOn) && batterySwitchOn);
	c_discharge: cover property (@(posedge ref_clk) dischargeOn);
	c_forced: cover property (@(posedge ref_clk) path_status_reg == PPS_SRC_FORCED_BATT);

endmodule : power_path_selector
`default_nettype wire

// ---- tb/pps_front_model.sv ----
// Far-side model: supply, load and pack comparators seen by the selector
`timescale 1ns/1ps
`default_nettype none
module pps_front_model (
	// Clock
	input  wire logic ref_clk,
	// Scenario commands
	input  wire logic adapterPlug,
	input  wire logic usbPlug,
	input  wire logic heavyLoad,
	input  wire logic packOut,
	// Comparator levels
	output logic      adapterAboveBat,
	output logic      usbAboveBat,
	output logic      busBelowBat,
	output logic      packIdTrip
);
	// Bus sags below the cell only while an overloaded input feeds it
	always_ff @(posedge ref_clk)
	begin
		adapterAboveBat <= adapterPlug;
		usbAboveBat     <= usbPlug;
		busBelowBat     <= heavyLoad & (adapterPlug | usbPlug);
		packIdTrip      <= packOut;
	end
endmodule : pps_front_model
`default_nettype wire

// ---- tb/power_path_selector_bench.sv ----
// Self-checking bench of the power path selector
`timescale 1ns/1ps
`default_nettype none
module power_path_selector_bench;
	import pps_pkg::*;
	localparam int BC = 20;
	localparam int FC = 8;
	// ==========================================
	// Signals
	// ==========================================
	logic ref_clk, sys_rst, adapterPlug, usbPlug, heavyLoad, packOut;
	logic adapterAboveBat, usbAboveBat, busBelowBat, packIdTrip, adapterOvp, usbOvp;
	logic busBelowShort, batBusShort, thermalShutdown, chargeCurrentZero, autoPathEnable;
	logic usbSourceSelect, usb_limit_high_select, chargeSuspend, sleepMode;
	logic adapterSwitchOn, usbSwitchOn, batterySwitchOn, inputPullupOn, batPullupOn;
	logic dischargeOn, packIdSourceOn, chargeEnable, chargeReduce, supplementNeed;
	logic overvoltageFlag, bootActive;
	logic [PACK_LEVEL_W-1:0] pack_id_current_level, packIdLevel;
	logic [1:0] usbLimitCode, adapterLimitCode;
	pps_src_t path_status_reg;
	logic [3:0] sw;
	int error_cnt, check_count;
	assign sw = {1'b0, adapterSwitchOn, usbSwitchOn, batterySwitchOn};
	// ==========================================
	// Instances
	// ==========================================
	pps_front_model u_pps_front_model (.ref_clk, .adapterPlug, .usbPlug, .heavyLoad,
		.packOut, .adapterAboveBat, .usbAboveBat, .busBelowBat, .packIdTrip);
	power_path_selector #(.BOOT_CNT(BC), .FILTER_CNT(FC)) u_power_path_selector (
		.ref_clk, .sys_rst, .adapterAboveBat, .usbAboveBat, .busBelowBat, .adapterOvp,
		.usbOvp, .busBelowShort, .batBusShort, .packIdTrip, .thermalShutdown,
		.chargeCurrentZero, .autoPathEnable, .usbSourceSelect, .usb_limit_high_select,
		.chargeSuspend, .sleepMode, .pack_id_current_level, .adapterSwitchOn, .usbSwitchOn,
		.batterySwitchOn, .inputPullupOn, .batPullupOn, .dischargeOn, .packIdSourceOn,
		.packIdLevel, .usbLimitCode, .adapterLimitCode, .chargeEnable, .chargeReduce,
		.supplementNeed, .overvoltageFlag, .bootActive, .path_status_reg);
	// ==========================================
	// Helpers
	// ==========================================
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wt
	task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_boot();
		wt(2);
		chk("boot", 4'(bootActive), 4'h1);
		chk("ilim", 4'(usbLimitCode), 4'h0);
		chk("chg", 4'(chargeEnable), 4'h1);
		chk("stat", 4'(path_status_reg), 4'h0);
		wt(BC + 4);
		chk("boot", 4'(bootActive), 4'h0);
		chk("ilim", 4'(usbLimitCode), 4'h2);
		chk("chg", 4'(chargeEnable), 4'h0);
		chk("sw", sw, 4'h1);
		chk("stat", 4'(path_status_reg), 4'h3);
		$display("boot test done");
	endtask : t_boot
	task automatic t_auto();
		logic [1:0] seq [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
		logic [3:0] esw [4] = '{4'h4, 4'h2, 4'h4, 4'h1};
		logic [3:0] est [4] = '{4'h1, 4'h2, 4'h1, 4'h0};
		@(posedge ref_clk);
		autoPathEnable <= 1'b1;
		chargeSuspend <= 1'b0;
		foreach (seq[k])
		begin
			@(posedge ref_clk);
			{adapterPlug, usbPlug} <= seq[k];
			wt(6);
			chk("sw", sw, esw[k]);
			chk("stat", 4'(path_status_reg), est[k]);
		end
		$display("auto path test done");
	endtask : t_auto
	task automatic t_supplement();
		@(posedge ref_clk);
		adapterPlug <= 1'b1;
		heavyLoad <= 1'b1;
		wt(6);
		chk("sup", 4'(supplementNeed), 4'h1);
		chk("reduce", 4'(chargeReduce), 4'h1);
		chk("sw", sw, 4'h4);
		@(posedge ref_clk);
		chargeCurrentZero <= 1'b1;
		wt(4);
		chk("sw", sw, 4'h5);
		@(posedge ref_clk);
		heavyLoad <= 1'b0;
		wt(6);
		chk("sw", sw, 4'h4);
		$display("supplement test done");
	endtask : t_supplement
	task automatic t_limits();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			{usbSourceSelect, usb_limit_high_select} <= 2'(i);
			wt(3);
			chk("ilim", 4'(usbLimitCode), (i > 1) ? 4'h2 : 4'(i));
			chk("alim", 4'(adapterLimitCode), 4'h2);
		end
		$display("limit test done");
	endtask : t_limits
	task automatic t_faults();
		@(posedge ref_clk);
		adapterOvp <= 1'b1;
		wt(6);
		chk("ovp", {3'h0, overvoltageFlag}, 4'h1);
		chk("sw", sw, 4'h4);
		@(posedge ref_clk);
		adapterOvp <= 1'b0;
		usbOvp <= 1'b1;
		thermalShutdown <= 1'b1;
		wt(6);
		chk("ovp", {3'h0, overvoltageFlag}, 4'h1);
		chk("sw", sw, 4'h1);
		chk("stat", 4'(path_status_reg), 4'h4);
		@(posedge ref_clk);
		usbOvp <= 1'b0;
		thermalShutdown <= 1'b0;
		busBelowShort <= 1'b1;
		wt(6);
		chk("insw", 4'(sw[2:1]), 4'h0);
		chk("pull", 4'(inputPullupOn), 4'h1);
		chk("ovp", {3'h0, overvoltageFlag}, 4'h0);
		@(posedge ref_clk);
		busBelowShort <= 1'b0;
		wt(6);
		chk("sw", sw, 4'h4);
		@(posedge ref_clk);
		adapterPlug <= 1'b0;
		batBusShort <= 1'b1;
		wt(6);
		chk("bat", 4'(batterySwitchOn), 4'h0);
		chk("bpull", 4'(batPullupOn), 4'h1);
		@(posedge ref_clk);
		batBusShort <= 1'b0;
		wt(6);
		chk("sw", sw, 4'h1);
		$display("fault test done");
	endtask : t_faults
	task automatic t_pack();
		int n = 0;
		@(posedge ref_clk);
		autoPathEnable <= 1'b0;
		{adapterPlug, usbPlug} <= 2'h3;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			pack_id_current_level <= 2'(i);
			sleepMode <= i[0];
			wt(3);
			chk("lvl", 4'(packIdLevel), 4'(i));
			chk("src", 4'(packIdSourceOn), 4'(!i[0]));
		end
		chk("sw", sw, 4'h1);
		@(posedge ref_clk);
		packOut <= 1'b1;
		wt(FC - 2);
		@(posedge ref_clk);
		packOut <= 1'b0;
		wt(FC + 4);
		chk("dis", 4'(dischargeOn), 4'h0);
		@(posedge ref_clk);
		packOut <= 1'b1;
		while (dischargeOn !== 1'b1 && n < 40)
		begin
			wt(1);
			n++;
		end
		chk("dis", 4'(dischargeOn), 4'h1);
		if (n >= 40)
			end_sim();
		chk("dgl", 4'(n >= FC), 4'h1);
		chk("sw", sw, 4'h1);
		$display("pack test done");
	endtask : t_pack
	// ==========================================
	// Main sequence
	// ==========================================
	initial
	begin
		{adapterPlug, usbPlug, heavyLoad, packOut, adapterOvp, usbOvp} = 6'h0;
		{busBelowShort, batBusShort, thermalShutdown, chargeCurrentZero} = 4'h0;
		{autoPathEnable, usb_limit_high_select, sleepMode} = 3'h0;
		{usbSourceSelect, chargeSuspend, sys_rst} = 3'h7;
		pack_id_current_level = 2'h0;
		error_cnt = 0;
		check_count = 0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_boot();
		t_auto();
		t_supplement();
		t_limits();
		t_faults();
		t_pack();
		end_sim();
	end
endmodule : power_path_selector_bench
`default_nettype wire
